// [src/pcms_pkg.sv]
// Purpose: constants for the phy configuration and media status register
// Assumes: 32-bit register reached over a plain strobe port
// Notes:   offsets are byte addresses
`default_nettype none
package pcms_pkg;
  localparam logic [7:0]  CFG_MEDIA_OFFS   = 8'h04;
  localparam logic [7:0]  ISR_OFFS         = 8'h10;
  localparam logic [31:0] CFG_MEDIA_RESET  = 32'h0000_0000;
  localparam int          LINK_GOOD_BIT    = 31;
  localparam int          FAST_SPEED_BIT   = 30;
  localparam int          FULL_DUPLEX_BIT  = 29;
  localparam int          POL_REV_BIT      = 28;
  localparam int          ANEG_DONE_BIT    = 27;
  localparam int          PHY_OPT_HI       = 23;
  localparam int          PHY_OPT_LO       = 18;
  localparam int          IRQ_AUTOCLR_BIT  = 17;
  localparam int          PAUSE_BIT        = 16;
  localparam int          ANEG_CODE_HI     = 15;
  localparam int          ANEG_CODE_LO     = 13;
  localparam int          EXTERNAL_PHY_MODE_BIT      = 12;
  localparam int          PHY_PWRDN_BIT    = 9;
  localparam logic [2:0]  ANEG_CODE_RESET  = 3'h0;
  localparam logic [5:0]  PHY_OPT_RESET    = 6'h00;

  typedef enum logic [2:0] {
    PCMS_F10H   = 3'b000,
    PCMS_A10HF  = 3'b001,
    PCMS_F100H  = 3'b010,
    PCMS_A10100H = 3'b011,
    PCMS_F10F   = 3'b100,
    PCMS_A100HF = 3'b101,
    PCMS_F100F  = 3'b110,
    PCMS_AALL   = 3'b111
  } pcms_aneg_code_t;
endpackage : pcms_pkg
`default_nettype wire

// [src/pcms_aneg_decode.sv]
// Purpose: turn the auto-negotiation select code into phy mode controls
// Assumes: code and pause bit come from registers
// Notes:   purely combinational; top registers the results
`default_nettype none
module pcms_aneg_decode (
  input  wire logic [2:0] autonegModeCode,
  input  wire logic       pauseCapabilityOffer,
  output logic            anegEnable,
  output logic            forceFast,
  output logic            forceFull,
  output logic [3:0]      advertise,
  output logic            advertisePause
);
  // advertise bits: {100F, 100H, 10F, 10H}
  always_comb begin
    anegEnable = 1'b0;
    forceFast  = 1'b0;
    forceFull  = 1'b0;
    advertise  = 4'h0;
    case (pcms_pkg::pcms_aneg_code_t'(autonegModeCode))
      pcms_pkg::PCMS_F10H: begin
        forceFast = 1'b0;
      end
      pcms_pkg::PCMS_F100H: begin
        forceFast = 1'b1;
      end
      pcms_pkg::PCMS_F10F: begin
        forceFull = 1'b1;
      end
      pcms_pkg::PCMS_F100F: begin
        forceFast = 1'b1;
        forceFull = 1'b1;
      end
      pcms_pkg::PCMS_A10HF: begin
        anegEnable = 1'b1;
        advertise  = 4'h3;
      end
      pcms_pkg::PCMS_A10100H: begin
        anegEnable = 1'b1;
        advertise  = 4'h5;
      end
      pcms_pkg::PCMS_A100HF: begin
        anegEnable = 1'b1;
        advertise  = 4'hC;
      end
      pcms_pkg::PCMS_AALL: begin
        anegEnable = 1'b1;
        advertise  = 4'hF;
      end
      default: begin
        anegEnable = 1'b0;
      end
    endcase
    // pause only makes sense alongside a full-duplex offer
    advertisePause = pauseCapabilityOffer & anegEnable & (advertise[3] | advertise[1]);
  end
endmodule // pcms_aneg_decode
`default_nettype wire

// [src/pcms_phy_config_media_status_reg.sv]
// Purpose: bits 31..27, 23..12 and the power-down bit of the configuration and media status register
// Assumes: phy status inputs synchronous to ref_clk; eeprom load is a pulse
// Notes:   bits 10..0 other than the phy power-down flag are not held here
`default_nettype none
module pcms_phy_config_media_status_reg (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        softReset,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrStb,
  input  wire logic        regRdStb,
  output logic      [31:0] regRdData,
  input  wire logic        eepromLoad,
  input  wire logic        eepromPause,
  input  wire logic [2:0]  eepromAnegCode,
  input  wire logic        linkGood,
  input  wire logic        fastSpeedInd,
  input  wire logic        fullDuplexInd,
  input  wire logic        polarityReversed,
  input  wire logic        autonegComplete,
  input  wire logic        phyIrqPending,
  output logic             phyIrqClear,
  output logic [5:0]       phyOptions,
  output logic             phyAnegEnable,
  output logic             phyForceFast,
  output logic             phyForceFull,
  output logic [3:0]       phyAdvertise,
  output logic             phyAdvertisePause,
  output logic             miiEnable,
  output logic             phyPowerDown
);
  // ************************************************************
  // register storage
  // ************************************************************
  logic [5:0] phyOpt_r;
  logic       irqAutoClr_r;
  logic       pause_r;
  logic [2:0] anegCode_r;
  logic       extPhy_r;
  logic       phyPwrDn_r;
  logic       statLink_r;
  logic       statFast_r;
  logic       statFull_r;
  logic       statPol_r;
  logic       statAneg_r;
  logic       cfgWr;
  logic       decAneg;
  logic       decFast;
  logic       decFull;
  logic [3:0] decAdv;
  logic       decPause;
  logic [31:0] readWord;
  logic       cfgRd;
  logic       isrRd;

  // ************************************************************
  // address decode
  // ************************************************************
  // one compare shared by the write, read and interrupt paths
  function automatic logic addrHit(input logic [7:0] addr, input logic [7:0] offs);
    return addr == offs;
  endfunction

  assign cfgWr = regWrStb && addrHit(regAddr, pcms_pkg::CFG_MEDIA_OFFS);
  assign cfgRd = regRdStb && addrHit(regAddr, pcms_pkg::CFG_MEDIA_OFFS);
  // the interrupt status register lives elsewhere; only its read is watched
  assign isrRd = regRdStb && addrHit(regAddr, pcms_pkg::ISR_OFFS);

  // ************************************************************
  // software-owned configuration bits
  // ************************************************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phyOpt_r <= pcms_pkg::PHY_OPT_RESET;
    end else if (softReset) begin
      phyOpt_r <= pcms_pkg::PHY_OPT_RESET;
    end else if (cfgWr) begin
      phyOpt_r <= regWrData[pcms_pkg::PHY_OPT_HI:pcms_pkg::PHY_OPT_LO];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irqAutoClr_r <= 1'b0;
    end else if (softReset) begin
      irqAutoClr_r <= 1'b0;
    end else if (cfgWr) begin
      irqAutoClr_r <= regWrData[pcms_pkg::IRQ_AUTOCLR_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      extPhy_r <= 1'b0;
    end else if (softReset) begin
      extPhy_r <= 1'b0;
    end else if (cfgWr) begin
      extPhy_r <= regWrData[pcms_pkg::EXTERNAL_PHY_MODE_BIT];
    end
  end

  // eeprom load wins over a software write in the same cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pause_r <= 1'b0;
    end else if (softReset) begin
      pause_r <= 1'b0;
    end else if (eepromLoad) begin
      pause_r <= eepromPause;
    end else if (cfgWr) begin
      pause_r <= regWrData[pcms_pkg::PAUSE_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      anegCode_r <= pcms_pkg::ANEG_CODE_RESET;
    end else if (softReset) begin
      anegCode_r <= pcms_pkg::ANEG_CODE_RESET;
    end else if (eepromLoad) begin
      anegCode_r <= eepromAnegCode;
    end else if (cfgWr) begin
      anegCode_r <= regWrData[pcms_pkg::ANEG_CODE_HI:pcms_pkg::ANEG_CODE_LO];
    end
  end

  // power-down is forced on while external phy mode is set
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phyPwrDn_r <= 1'b0;
    end else if (softReset) begin
      phyPwrDn_r <= 1'b0;
    end else if (cfgWr) begin
      phyPwrDn_r <= regWrData[pcms_pkg::PHY_PWRDN_BIT] | regWrData[pcms_pkg::EXTERNAL_PHY_MODE_BIT];
    end
  end

  // ************************************************************
  // status capture: writes never touch these
  // ************************************************************
  // one flop of lag keeps the read mux off the phy's own timing paths;
  // a read therefore shows the phy state of the previous clock
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      statLink_r <= 1'b0;
    end else begin
      statLink_r <= linkGood;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      statFast_r <= 1'b0;
    end else begin
      statFast_r <= fastSpeedInd;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      statFull_r <= 1'b0;
    end else begin
      statFull_r <= fullDuplexInd;
    end
  end

  // reversed polarity means nothing at 100 Mb/s, so it is masked there
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      statPol_r <= 1'b0;
    end else begin
      statPol_r <= polarityReversed & ~fastSpeedInd;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      statAneg_r <= 1'b0;
    end else begin
      statAneg_r <= autonegComplete | ~decAneg;
    end
  end

  pcms_aneg_decode uDecode (
    .autonegModeCode      (anegCode_r),
    .pauseCapabilityOffer (pause_r),
    .anegEnable           (decAneg),
    .forceFast            (decFast),
    .forceFull            (decFull),
    .advertise            (decAdv),
    .advertisePause       (decPause)
  );

  // ************************************************************
  // phy control outputs
  // ************************************************************
  // every control is a flop so decode glitches never reach the phy
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phyOptions <= pcms_pkg::PHY_OPT_RESET;
    end else begin
      phyOptions <= phyOpt_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phyAnegEnable     <= 1'b0;
      phyForceFast      <= 1'b0;
      phyForceFull      <= 1'b0;
      phyAdvertise      <= 4'h0;
      phyAdvertisePause <= 1'b0;
    end else begin
      phyAnegEnable     <= decAneg;
      phyForceFast      <= decFast;
      phyForceFull      <= decFull;
      phyAdvertise      <= decAdv;
      phyAdvertisePause <= decPause;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      miiEnable <= 1'b0;
    end else begin
      miiEnable <= extPhy_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phyPowerDown <= 1'b0;
    end else begin
      phyPowerDown <= phyPwrDn_r;
    end
  end

  // a status read clears the phy source only when auto-clear is enabled;
  // otherwise software must go through the phy's own registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phyIrqClear <= 1'b0;
    end else begin
      phyIrqClear <= isrRd && irqAutoClr_r && phyIrqPending;
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  always_comb begin
    readWord = 32'h0000_0000;
    readWord[pcms_pkg::LINK_GOOD_BIT]   = statLink_r;
    readWord[pcms_pkg::FAST_SPEED_BIT]  = statFast_r;
    readWord[pcms_pkg::FULL_DUPLEX_BIT] = statFull_r;
    readWord[pcms_pkg::POL_REV_BIT]     = statPol_r;
    readWord[pcms_pkg::ANEG_DONE_BIT]   = statAneg_r;
    readWord[pcms_pkg::PHY_OPT_HI:pcms_pkg::PHY_OPT_LO] = phyOpt_r;
    readWord[pcms_pkg::IRQ_AUTOCLR_BIT] = irqAutoClr_r;
    readWord[pcms_pkg::PAUSE_BIT]       = pause_r;
    readWord[pcms_pkg::ANEG_CODE_HI:pcms_pkg::ANEG_CODE_LO] = anegCode_r;
    readWord[pcms_pkg::EXTERNAL_PHY_MODE_BIT]     = extPhy_r;
    readWord[pcms_pkg::PHY_PWRDN_BIT]   = phyPwrDn_r;
  end

  // unmapped offsets read zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      regRdData <= 32'h0000_0000;
    end else if (cfgRd) begin
      regRdData <= readWord;
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end
endmodule // pcms_phy_config_media_status_reg
`default_nettype wire

// [tb/pcms_phy_model.sv]
// Purpose: behavioural internal phy facing the register block
// Assumes: status levels chosen by the bench through st
// Notes:   power-down drops the link, as a real phy would
`default_nettype none
module pcms_phy_model (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic [4:0] st,
  input  wire logic       irqSet,
  input  wire logic       phyIrqClear,
  input  wire logic       phyPowerDown,
  output logic            linkGood,
  output logic            fastSpeedInd,
  output logic            fullDuplexInd,
  output logic            polarityReversed,
  output logic            autonegComplete,
  output var logic        phyIrqPending
);
  timeunit 1ns;
  timeprecision 1ns;
  assign linkGood = st[4] && !phyPowerDown;
  assign {fastSpeedInd, fullDuplexInd, polarityReversed, autonegComplete} = st[3:0];
  // pending holds until a clear pulse, never drops by itself
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) phyIrqPending <= 1'b0;
    else if (irqSet) phyIrqPending <= 1'b1;
    else if (phyIrqClear) phyIrqPending <= 1'b0;
  end
endmodule // pcms_phy_model
`default_nettype wire

// [tb/pcms_sva.sv]
// Purpose: port assertions for the config and media status register
// Assumes: a status read is judged only after 3 quiet cycles
// Notes:   bit 17 is shadowed from the write port
`default_nettype none
module pcms_sva (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        softReset,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWrStb,
  input wire logic        regRdStb,
  input wire logic [31:0] regRdData,
  input wire logic        linkGood,
  input wire logic        fastSpeedInd,
  input wire logic        fullDuplexInd,
  input wire logic        polarityReversed,
  input wire logic        autonegComplete,
  input wire logic        phyIrqPending,
  input wire logic        phyIrqClear,
  input wire logic [5:0]  phyOptions,
  input wire logic        phyAnegEnable,
  input wire logic [3:0]  phyAdvertise,
  input wire logic        phyAdvertisePause,
  input wire logic        miiEnable,
  input wire logic        phyPowerDown
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] stNow, stPrev;
  logic [1:0] stCnt;
  logic       acen;
  wire logic  rdOk;
  assign stNow = {linkGood, fastSpeedInd, fullDuplexInd, polarityReversed, autonegComplete};
  assign rdOk = regRdStb && regAddr == 8'h04 && stCnt == 2'h3;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) stPrev <= 5'h00;
    else stPrev <= stNow;
  end
  // saturating count of edges with unchanged status
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) stCnt <= 2'h0;
    else if (stNow != stPrev) stCnt <= 2'h0;
    else if (stCnt != 2'h3) stCnt <= stCnt + 2'h1;
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) acen <= 1'b0;
    else if (softReset) acen <= 1'b0;
    else if (regWrStb && regAddr == 8'h04) acen <= regWrData[17];
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_link_state: assert property ($past(rdOk) |-> regRdData[31] == $past(linkGood, 2))
    else $error("link bit wrong");
  a_speed_dup: assert property ($past(rdOk) |->
    regRdData[30:29] == $past({fastSpeedInd, fullDuplexInd}, 2)) else $error("speed or duplex wrong");
  a_pol_gate: assert property ($past(rdOk) |->
    regRdData[28] == $past(polarityReversed && !fastSpeedInd, 2)) else $error("polarity bit wrong");
  a_unused_zero: assert property ($past(regRdStb) |->
    regRdData[26:24] == 3'h0 && !regRdData[11]) else $error("unused bits not zero");
  a_irq_autoclr: assert property (regRdStb && regAddr == 8'h10 && phyIrqPending && acen
    |=> phyIrqClear) else $error("phy irq not cleared");
  a_irq_cause: assert property (phyIrqClear |->
    $past(regRdStb && regAddr == 8'h10 && acen)) else $error("stray phy irq clear");
  a_opt_follow: assert property (regWrStb && regAddr == 8'h04 && !softReset ##1 !softReset
    |-> ##1 phyOptions == $past(regWrData[23:18], 2)) else $error("phy options stale");
  a_mii_follow: assert property (regWrStb && regAddr == 8'h04 && !softReset ##1 !softReset
    |-> ##1 miiEnable == $past(regWrData[12], 2)
    && phyPowerDown == $past(regWrData[9] | regWrData[12], 2)) else $error("mii or power wrong");
  a_soft_clear: assert property (softReset |=> ##1 phyOptions == 6'h00 && !miiEnable
    && !phyPowerDown && !phyAnegEnable) else $error("soft reset left config");
  a_pause_gate: assert property (phyAdvertisePause |->
    phyAnegEnable && (phyAdvertise[3] || phyAdvertise[1])) else $error("pause without full");
endmodule // pcms_sva
bind pcms_phy_config_media_status_reg pcms_sva i_pcms_sva (.*);
`default_nettype wire

// [tb/phy_config_media_status_reg_bench.sv]
// Purpose: self-checking bench for the config and media status register
// Assumes: design and phy model share port names, joined by name
// Notes:   bits 10..0 are not compared; bit 9 among them is held in this block
`default_nettype none
module phy_config_media_status_reg_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        softReset = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0000_0000;
  logic        regWrStb = 1'b0;
  logic        regRdStb = 1'b0;
  logic        eepromLoad = 1'b0;
  logic        eepromPause = 1'b0;
  logic [2:0]  eepromAnegCode = 3'h0;
  logic [4:0]  st = 5'h00;
  logic        irqSet = 1'b0;
  logic [31:0] regRdData, rd, w;
  logic        linkGood, fastSpeedInd, fullDuplexInd, polarityReversed, autonegComplete;
  logic        phyIrqPending, phyIrqClear, phyAnegEnable, phyForceFast, phyForceFull;
  logic        phyAdvertisePause, miiEnable, phyPowerDown;
  logic [5:0]  phyOptions;
  logic [3:0]  phyAdvertise;
  integer      seed = 56;
  int          err_total = 0;
  int          n_tests = 0;
  always #50 ref_clk = ~ref_clk;
  pcms_phy_config_media_status_reg i_pcms_phy_config_media_status_reg (.*);
  pcms_phy_model i_pcms_phy_model (.*);
  // **********************************
  // helpers
  // **********************************
  function automatic logic [20:0] expv(input logic [31:0] v);
    return {st[4] & ~(v[9] | v[12]), st[3:2], st[1] & ~st[3], st[0] | ~v[13], 3'h0, v[23:12], 1'b0};
  endfunction
  function automatic logic [3:0] adv(input logic [1:0] c);
    return (c == 2'h0) ? 4'h3 : (c == 2'h1) ? 4'h5 : (c == 2'h2) ? 4'hC : 4'hF;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (e !== s) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    #1 rd = regRdData;
    @(posedge ref_clk);
  endtask
  task automatic print_verdict;
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk);
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 24; i++) begin
      w = $random(seed);
      w[15:13] = i[2:0];
      st <= 5'($random(seed));
      wr(pcms_pkg::CFG_MEDIA_OFFS, w);
      repeat (4) @(posedge ref_clk);
      rd_reg(pcms_pkg::CFG_MEDIA_OFFS);
      chk("cfg", {expv(w), 11'h000}, {rd[31:11], 11'h000});
      chk("ctl", {18'h0_0000, w[23:18], w[12], w[9] | w[12], w[13],
        w[16] & w[13] & (w[15] | ~w[14]), w[13] ? adv(w[15:14]) : {2'h0, w[15:14]}},
        {18'h0_0000, phyOptions, miiEnable, phyPowerDown, phyAnegEnable, phyAdvertisePause,
        w[13] ? phyAdvertise : {2'h0, phyForceFull, phyForceFast}});
    end
    for (int k = 0; k < 2; k++) begin
      wr(pcms_pkg::CFG_MEDIA_OFFS, {14'h0000, k[0], 17'h0_0000});
      irqSet <= 1'b1;
      @(posedge ref_clk);
      irqSet <= 1'b0;
      rd_reg(pcms_pkg::ISR_OFFS);
      @(posedge ref_clk);
      chk("irq", {31'h0, ~k[0]}, {31'h0, phyIrqPending});
    end
    eepromPause <= 1'b1;
    eepromAnegCode <= 3'h5;
    eepromLoad <= 1'b1;
    @(posedge ref_clk);
    eepromLoad <= 1'b0;
    rd_reg(pcms_pkg::CFG_MEDIA_OFFS);
    chk("eeprom", 32'h0000_000D, {28'h000_0000, rd[16:13]});
    for (int k = 0; k < 2; k++) begin
      wr(pcms_pkg::CFG_MEDIA_OFFS, 32'hFFFF_FFFF);
      if (k == 0) softReset <= 1'b1;
      else rstn <= 1'b0;
      @(posedge ref_clk);
      softReset <= 1'b0;
      rstn <= 1'b1;
      @(posedge ref_clk);
      rd_reg(pcms_pkg::CFG_MEDIA_OFFS);
      chk("clear", 32'h0000_0000, {8'h00, rd[23:12], 12'h000});
    end
    print_verdict();
  end
endmodule // phy_config_media_status_reg_bench
`default_nettype wire
